//--- rtl/ssc_map.vh
// Constants for the stepper sequencer and chopper block.
// Assumes a 25 MHz pclk; all counts derive from it.
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// Clock rate
`define SSC_CLK_MHZ      25

// Times in ns
`define SSC_DT_NS        1000
`define SSC_BLANK_NS     1000
`define SSC_MINON_NS     1500

// Cycle counts: least times round up
`define SSC_DT_CYC       ((`SSC_DT_NS * `SSC_CLK_MHZ + 999) / 1000)
`define SSC_BLANK_CYC    ((`SSC_BLANK_NS * `SSC_CLK_MHZ + 999) / 1000)
`define SSC_MINON_CYC    ((`SSC_MINON_NS * `SSC_CLK_MHZ + 999) / 1000)

// Register byte offsets
`define SSC_CTRL_OFS     12'h000
`define SSC_TOFF_OFS     12'h004
`define SSC_STAT_OFS     12'h008

// Control fields
`define SSC_CTRL_DIR     0
`define SSC_CTRL_HALF    1
`define SSC_CTRL_SLOW    2
`define SSC_CTRL_SRST    3

// Reset values
`define SSC_CTRL_RST     4'h3
`define SSC_TOFF_RST     16'h0145

`endif

//--- rtl/ssc_top.v
// Stepper phase sequencer with two constant-off-time current choppers.
// Assumes synchronous pins, an APB master on pclk, external comparators.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.vh"

// ----------------------------------------------------------------
// One bridge chopper
// ----------------------------------------------------------------
module ssc_chop
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Control
  input  wire        run,
  input  wire        pol,
  input  wire        slow,
  input  wire        cmp,
  input  wire [15:0] off_cyc,
  // Gates {hs1, ls1, hs2, ls2}
  output reg  [3:0]  gate_q,
  output wire        off_st
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PRE  = 3'h1;
  localparam [2:0] ST_ON   = 3'h2;
  localparam [2:0] ST_OFF  = 3'h3;
  localparam [2:0] ST_REST = 3'h4;
  localparam integer DT_I  = `SSC_DT_CYC;
  localparam integer BLK_I = `SSC_BLANK_CYC;
  localparam integer MON_I = `SSC_MINON_CYC;
  localparam [5:0] DT_C    = DT_I[5:0];
  localparam [5:0] BLK_C   = BLK_I[5:0];
  localparam [5:0] MON_C   = MON_I[5:0];

  reg [2:0]  st_q;
  reg [5:0]  dt_q;
  reg [5:0]  on_q;
  reg [15:0] off_q;
  reg        pol_q;
  reg        slow_q;
  reg [3:0]  gate_d;
  wire       ok_trip;

  assign off_st = (st_q == ST_OFF) || (st_q == ST_REST);
  // [R06] Blanking mask
  // [R07] Minimum on time
  // [R27] No retrigger
  assign ok_trip = (on_q >= BLK_C) && (on_q >= MON_C);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= ST_IDLE;
      dt_q  <= 6'h00;
      on_q  <= 6'h00;
      off_q <= 16'h0000;
      pol_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else if (!run || (pol != pol_q && st_q != ST_IDLE))
    begin
      st_q  <= ST_IDLE;
      pol_q <= pol;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          st_q <= ST_PRE;
          dt_q <= DT_C - 6'h01;
        end
        ST_PRE:
        begin
          if (dt_q == 6'h00)
          begin
            st_q <= ST_ON;
            on_q <= 6'h00;
          end
          else
            dt_q <= dt_q - 6'h01;
        end
        ST_ON:
        begin
          if (on_q != 6'h3F)
            on_q <= on_q + 6'h01;
          // [R02] Trip starts off timer
          if (cmp && ok_trip)
          begin
            // Full gap before recirculation; decay mode held for the whole off period
            st_q  <= ST_OFF;
            dt_q  <= DT_C;
            slow_q <= slow;
            off_q <= (off_cyc == 16'h0000) ? 16'h0000 : off_cyc - 16'h0001;
          end
        end
        ST_OFF:
        begin
          if (dt_q != 6'h00)
            dt_q <= dt_q - 6'h01;
          // [R03] Stay off for timer
          if (off_q == 16'h0000)
          begin
            st_q <= ST_REST;
            dt_q <= DT_C - 6'h01;
          end
          else
            off_q <= off_q - 16'h0001;
        end
        ST_REST:
        begin
          // [R04] Turn-on after deadtime
          // [R05] Deadtime length
          if (dt_q == 6'h00)
          begin
            st_q <= ST_ON;
            on_q <= 6'h00;
          end
          else
            dt_q <= dt_q - 6'h01;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Gate pattern; conducting pair is hs1/ls2 for pol high
  always @*
  begin
    gate_d = 4'h0;
    case (st_q)
      ST_ON:
        gate_d = pol_q ? 4'h9 : 4'h6;
      ST_OFF:
      begin
        if (slow_q)
        begin
          // [R10] Slow decay drops low side
          // [R13] Other high side after gap
          if (pol_q)
            gate_d = (dt_q == 6'h00) ? 4'hA : 4'h8;
          else
            gate_d = (dt_q == 6'h00) ? 4'hA : 4'h2;
        end
        else
        begin
          // [R09] Fast decay all off
          // [R11] Only low side rectifies
          if (pol_q)
            gate_d = (dt_q == 6'h00) ? 4'h4 : 4'h0;
          else
            gate_d = (dt_q == 6'h00) ? 4'h1 : 4'h0;
        end
      end
      ST_REST:
      begin
        // [R12] Fast restore after gap
        // [R14] Slow low side after gap
        if (slow_q)
          gate_d = pol_q ? 4'h8 : 4'h2;
        else
          gate_d = 4'h0;
      end
      default:
        gate_d = 4'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_q <= 4'h0;
    else
      gate_q <= gate_d;
  end
endmodule // ssc_chop

// ----------------------------------------------------------------
// Top: APB registers, sequencer, protection pin
// ----------------------------------------------------------------
// Functional notes
// [R01] Two independent choppers, one per bridge, fixed off interval.
// [R02] Comparator trip starts off timer and turns bridge off.
// [R03] Bridge stays off for whole timer, then turns back on.
// [R04] Turn-on delayed by deadtime; off period is timer plus deadtime.
// [R05] Each leg deadtime is 1 microsecond.
// [R06] Comparator ignored for 1 microsecond after turn-on.
// [R07] Minimum on time of 1.5 microseconds each cycle.
// [R08] Off timer length is a programmable constant set outside.
// [R09] Decay select low: fast decay, both conducting transistors off.
// [R10] Decay select high: slow decay, only low side off.
// [R11] Fast decay rectifies with the low side only.
// [R12] Fast decay restores on-state after a deadtime.
// [R13] Slow decay turns other high side on after deadtime.
// [R14] Slow decay restores low side after a deadtime.
// [R15] Sequencer state gives phase polarity and enables for both bridges.
// [R16] Each step clock rising edge advances one step in set direction.
// [R17] Reset puts sequencer in state 1.
// [R18] Drive mode depends on step size input and current state.
// [R19] Half step moves one state per clock, up or down.
// [R20] Protection shares the enable pin and can pull it low.
// [R21] Host drives enable pin through pull-up and capacitor.
// [R22] Full step from odd state: 1,3,5,7 or 1,7,5,3.
// [R23] Full step from even state: even states only.
// [R24] Overcurrent pulls enable pin low through open drain.
// [R25] Enable low holds all transistors off, state kept.
// [R26] Sequencer wraps modulo eight both ways.
// [R27] Off timer not retriggered; trips only after minimum on and blank.
module ssc_top
(
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Host pins
  input  wire        step_clk,
  // Comparators and protection
  input  wire        cmp_a,
  input  wire        cmp_b,
  input  wire        overcurrent_detector,
  input  wire        thermal_fault,
  // Shared enable pin
  input  wire        enable_pin_i,
  output wire        enable_pin_o,
  output wire        enable_pin_oe_n,
  // Bridge gates {hs1, ls1, hs2, ls2}
  output wire [3:0]  gate_a,
  output wire [3:0]  gate_b
);
  reg  [3:0]  ctrl_q;
  reg  [15:0] toff_q;
  reg  [2:0]  seq_q;
  reg         step_q;
  reg  [3:0]  ph;
  wire        hit_ctrl;
  wire        hit_toff;
  wire        hit_stat;
  wire        wr;
  wire        step_rise;
  wire        off_a;
  wire        off_b;
  wire [31:0] stat;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign hit_ctrl = (paddr == `SSC_CTRL_OFS);
  assign hit_toff = (paddr == `SSC_TOFF_OFS);
  assign hit_stat = (paddr == `SSC_STAT_OFS);
  assign wr       = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_ctrl || hit_toff || hit_stat);
  assign stat     = {22'h0, enable_pin_i, off_b, off_a, ph, 3'h0} | {29'h0, seq_q};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `SSC_CTRL_RST;
      toff_q <= `SSC_TOFF_RST;
    end
    else
    begin
      ctrl_q[`SSC_CTRL_SRST] <= 1'b0;
      if (wr && hit_ctrl)
        ctrl_q <= pwdata[3:0];
      // [R08] Programmable off time
      if (wr && hit_toff)
        toff_q <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      if (hit_ctrl)
        prdata <= {28'h0000000, ctrl_q};
      else if (hit_toff)
        prdata <= {16'h0000, toff_q};
      else if (hit_stat)
        prdata <= stat;
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  assign step_rise = step_clk && !step_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // [R17] State 1 at reset
      seq_q  <= 3'h0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= step_clk;
      if (ctrl_q[`SSC_CTRL_SRST])
        seq_q <= 3'h0;
      // [R16] Advance on rising edge
      else if (step_rise)
      begin
        // [R18] Mode from input and state
        // [R19] Half step by one
        // [R22] Odd full step by two
        // [R23] Even full step by two
        // [R26] Wraps modulo eight
        if (ctrl_q[`SSC_CTRL_HALF])
          seq_q <= ctrl_q[`SSC_CTRL_DIR] ? seq_q + 3'h1 : seq_q - 3'h1;
        else
          seq_q <= ctrl_q[`SSC_CTRL_DIR] ? seq_q + 3'h2 : seq_q - 3'h2;
      end
    end
  end

  // [R15] State to {pol A, en A, pol B, en B}
  always @*
  begin
    case (seq_q)
      3'h0:    ph = 4'hF;
      3'h1:    ph = 4'h3;
      3'h2:    ph = 4'h7;
      3'h3:    ph = 4'h4;
      3'h4:    ph = 4'h5;
      3'h5:    ph = 4'h1;
      3'h6:    ph = 4'hD;
      3'h7:    ph = 4'hC;
      default: ph = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Enable pin and bridges
  // ----------------------------------------------------------------
  // [R20] Protection shares enable pin
  // [R24] Open drain pulls it low
  assign enable_pin_o    = 1'b0;
  assign enable_pin_oe_n = !(overcurrent_detector || thermal_fault);

  // [R01] Two independent choppers
  // [R25] Enable low keeps gates off
  ssc_chop u_chop_a
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enable_pin_i && ph[2]),
    .pol     (ph[3]),
    .slow    (ctrl_q[`SSC_CTRL_SLOW]),
    .cmp     (cmp_a),
    .off_cyc (toff_q),
    .gate_q  (gate_a),
    .off_st  (off_a)
  );

  ssc_chop u_chop_b
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enable_pin_i && ph[0]),
    .pol     (ph[1]),
    .slow    (ctrl_q[`SSC_CTRL_SLOW]),
    .cmp     (cmp_b),
    .off_cyc (toff_q),
    .gate_q  (gate_b),
    .off_st  (off_b)
  );
endmodule // ssc_top

`default_nettype wire

//--- testbench/ssc_top_monitor.sv
// Checker on the top ports of the stepper block.
// Assumes gates {hs1,ls1,hs2,ls2} and a 25-cycle gap.
`timescale 1ns/1ps
`default_nettype none
module ssc_top_monitor
(
  // Watched ports
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       enable_pin_i,
  input wire logic       enable_pin_oe_n,
  input wire logic       overcurrent_detector,
  input wire logic [3:0] gate_a,
  input wire logic [3:0] gate_b
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_fast_off;
    gate_a == 4'h0 && $past(gate_a) == 4'h9;
  endsequence
  sequence s_slow_off;
    gate_b == 4'h8 && $past(gate_b) == 4'h9;
  endsequence
  AST_OVERCURRENT: assert property (overcurrent_detector |-> !enable_pin_oe_n)
    else $error("fault pin not pulled");
  AST_ENOFF: assert property (!enable_pin_i [*2] |=> gate_a == 4'h0 && gate_b == 4'h0)
    else $error("gates on while disabled");
  AST_LEG: assert property (!(gate_a[3] & gate_a[2]) && !(gate_a[1] & gate_a[0])
    && !(gate_b[3] & gate_b[2]) && !(gate_b[1] & gate_b[0])) else $error("leg shorted");
  AST_GAP_A: assert property ($fell(gate_a[2]) |=> !gate_a[3] [*8] ##1 !gate_a[3] [*8]
    ##1 !gate_a[3] [*8]) else $error("restore gap short");
  AST_GAP_B1: assert property ($fell(gate_b[0]) |=> !gate_b[1] [*8] ##1 !gate_b[1] [*8]
    ##1 !gate_b[1] [*8]) else $error("recirculation gap short");
  AST_GAP_B2: assert property ($fell(gate_b[1]) |=> !gate_b[0] [*8] ##1 !gate_b[0] [*8]
    ##1 !gate_b[0] [*8]) else $error("low side back early");
  AST_FAST: assert property (s_fast_off |=> (gate_a == 4'h0) [*8] ##1 (gate_a == 4'h0) [*8]
    ##1 (gate_a == 4'h0) [*8]) else $error("fast decay gap wrong");
  AST_SLOW: assert property (s_slow_off |=> (gate_b == 4'h8) [*8] ##1 (gate_b == 4'h8) [*8]
    ##1 (gate_b == 4'h8) [*8]) else $error("slow decay gap wrong");
endmodule // ssc_top_monitor
bind ssc_top ssc_top_monitor i_ssc_top_monitor (.pclk(pclk), .presetn(presetn), .enable_pin_i(enable_pin_i),
  .enable_pin_oe_n(enable_pin_oe_n), .overcurrent_detector(overcurrent_detector), .gate_a(gate_a), .gate_b(gate_b));
`default_nettype wire

//--- testbench/ssc_host.sv
// Host model: step pin and the pulled-up enable pin.
// Assumes the bench calls pulse right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ssc_host
(
  // Clock
  input  wire logic pclk,
  // Enable pin parties
  input  wire logic en_drive,
  input  wire logic enable_pin_o,
  input  wire logic enable_pin_oe_n,
  // Pins to the device
  output var  logic step_clk,
  output wire logic enable_pin_i
);
  assign enable_pin_i = en_drive & (enable_pin_oe_n | enable_pin_o);
  initial step_clk = 1'b0;
  task automatic pulse();
    repeat (2) @(posedge pclk);
    step_clk <= 1'b1;
    repeat (2) @(posedge pclk);
    step_clk <= 1'b0;
  endtask
endmodule // ssc_host
`default_nettype wire

//--- testbench/stepper_sequencer_chopper_tb.sv
// Self-checking bench for the stepper sequencer and chopper.
// Assumes the host model and the register map header.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_map.vh"
module stepper_sequencer_chopper_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        cmp_a = 1'b0;
  logic        cmp_b = 1'b0;
  logic        fault_oc = 1'b0;
  logic        thermal_fault = 1'b0;
  logic        en_drive = 1'b1;
  logic        er;
  logic [31:0] rd;
  wire         step_clk, enable_pin_i, enable_pin_o, enable_pin_oe_n, pready, pslverr;
  wire  [31:0] prdata;
  wire  [3:0]  gate_a, gate_b;
  int          failures = 0, checked = 0, cycles = 0, st = 0, n = 0;
  always #20 pclk = ~pclk;
  ssc_top i_ssc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_clk(step_clk),
    .cmp_a(cmp_a), .cmp_b(cmp_b), .overcurrent_detector(fault_oc), .thermal_fault(thermal_fault),
    .enable_pin_i(enable_pin_i), .enable_pin_o(enable_pin_o), .enable_pin_oe_n(enable_pin_oe_n),
    .gate_a(gate_a), .gate_b(gate_b));
  ssc_host i_ssc_host (.pclk(pclk), .en_drive(en_drive), .enable_pin_o(enable_pin_o),
    .enable_pin_oe_n(enable_pin_oe_n), .step_clk(step_clk), .enable_pin_i(enable_pin_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [3:0] g(input logic b);
    return b ? gate_b : gate_a;
  endfunction
  task automatic run(input logic b, input logic [3:0] v);
    n = 0;
    while (g(b) === v)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic regs();
    apb(1'b0, `SSC_CTRL_OFS, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, `SSC_TOFF_OFS, 32'h0);
    check(rd, 32'h145);
    apb(1'b0, `SSC_STAT_OFS, 32'h0);
    check({25'h0, rd[6:0]}, 32'h78);
    apb(1'b0, 12'h00C, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    // Short off time keeps the chop runs brief
    apb(1'b1, `SSC_TOFF_OFS, 32'h28);
  endtask
  task automatic chop(input logic b, input logic [3:0] on, input logic [3:0] dt, input logic [3:0] rc);
    run(b, ~on);
    run(b, dt);
    run(b, 4'h0);
    if (b)
      cmp_b <= 1'b1;
    else
      cmp_a <= 1'b1;
    run(b, on);
    run(b, dt);
    check(n, 25);
    run(b, rc);
    check(n, 15);
    run(b, dt);
    check(n, 25);
    run(b, on);
    check(n >= 38 && n <= 39, 1);
    cmp_a <= 1'b0;
    cmp_b <= 1'b0;
  endtask
  task automatic seq(input logic [31:0] ctrl, input int d, input int cnt);
    apb(1'b1, `SSC_CTRL_OFS, ctrl);
    repeat (cnt)
    begin
      i_ssc_host.pulse();
      st = (st + d + 8) % 8;
      apb(1'b0, `SSC_STAT_OFS, 32'h0);
      check({29'h0, rd[2:0]}, st);
    end
  endtask
  task automatic prot(input logic oc, input logic th, input logic en);
    fault_oc <= oc;
    thermal_fault <= th;
    en_drive <= en;
    i_ssc_host.pulse();
    st = (st + 1) % 8;
    check({enable_pin_oe_n, enable_pin_i, gate_a, gate_b}, {~(oc | th), 9'h0});
    apb(1'b0, `SSC_STAT_OFS, 32'h0);
    check({22'h0, rd[9:7], 4'h0, rd[2:0]}, st);
    fault_oc <= 1'b0;
    thermal_fault <= 1'b0;
    en_drive <= 1'b1;
    @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs();
    chop(1'b0, 4'h9, 4'h0, 4'h4);
    check(gate_b, 4'h9);
    apb(1'b1, `SSC_CTRL_OFS, 32'h7);
    chop(1'b1, 4'h9, 4'h8, 4'hA);
    prot(1'b1, 1'b0, 1'b1);
    prot(1'b0, 1'b1, 1'b1);
    prot(1'b0, 1'b0, 1'b0);
    apb(1'b1, `SSC_CTRL_OFS, 32'hB);
    st = 0;
    seq(32'h3, 1, 9);
    seq(32'h2, -1, 3);
    apb(1'b1, `SSC_CTRL_OFS, 32'h9);
    st = 0;
    seq(32'h1, 2, 5);
    seq(32'h0, -2, 3);
    apb(1'b1, `SSC_CTRL_OFS, 32'hB);
    st = 0;
    seq(32'h3, 1, 1);
    seq(32'h1, 2, 5);
    seq(32'h0, -2, 2);
    summarize();
  end
endmodule // stepper_sequencer_chopper_tb
`default_nettype wire
